//--- rtl/pirs_map.vh
// Register map, field layout and selector codes of the input remap selects
`ifndef PIRS_MAP_VH
`define PIRS_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PIRS_OFS_OC_FAULT_A   8'h00
`define PIRS_OFS_PWM_FAULT    8'h04
`define PIRS_OFS_ENC1_PHASE   8'h08
`define PIRS_OFS_ENC1_HOMEIDX 8'h0c
`define PIRS_OFS_ENC2_PHASE   8'h10
`define PIRS_OFS_ENC2_HOMEIDX 8'h14
`define PIRS_OFS_UART1_RX     8'h18
`define PIRS_OFS_UART2_RX     8'h1c
`define PIRS_NUM_REGS         8
`define PIRS_IDX_W            3

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define PIRS_SEL_W            7
`define PIRS_LO_LSB           0
`define PIRS_HI_LSB           8
`define PIRS_MASK_ONE         16'h007f
`define PIRS_MASK_TWO         16'h7f7f
`define PIRS_SEL_RESET        16'h0000

// ----------------------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------------------
`define PIRS_CODE_GROUND      7'h00
`define PIRS_CODE_COMPARATOR_ONE_OUTPUT        7'h01
`define PIRS_CODE_TOP_STD     7'h7c
`define PIRS_CODE_TOP_WIDE    7'h7f
`define PIRS_NUM_PINS         128

// ----------------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------------
`define PIRS_RESP_OKAY        2'b00
`define PIRS_RESP_DECERR      2'b11

`endif

//--- rtl/pirs_remap.v
// Peripheral input remap selectors with AXI4-Lite register access
`include "pirs_map.vh"
`default_nettype none

// How it works
// - Output compare fault A from low selector
// - PWM fault two from upper selector
// - PWM fault one from low selector
// - Encoder one phase B upper, A lower
// - Encoder one home upper, index lower
// - Encoder two phases, wide pin range
// - Encoder two home upper, index lower
// - UART one receive from low selector
// - UART two receive from low selector
// - Most selectors top code is pin 124
// - Encoder two phase code 127 is pin 127
// - Code one routes comparator one output
// - Code zero ties input to ground
// - Bits outside selector fields read zero
// - Selectors read/write, cleared at reset
module pirs_remap #(
  parameter ADDR_W = 8
) (
  input  wire                clk,
  input  wire                srst,
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]          s_axi_awprot,
  input  wire                s_axi_awvalid,
  output reg                 s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output reg                 s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]          s_axi_arprot,
  input  wire                s_axi_arvalid,
  output reg                 s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  // Sources
  input  wire [127:0]        remappable_pin,
  input  wire                comparator_one_output,
  // Peripheral inputs
  output wire                oc_fault_a_input,
  output wire                pwm_fault1_input,
  output wire                pwm_fault2_input,
  output wire                enc1_phase_a_input,
  output wire                enc1_phase_b_input,
  output wire                enc1_home_input,
  output wire                enc1_index_input,
  output wire                enc2_phase_a_input,
  output wire                enc2_phase_b_input,
  output wire                enc2_home_input,
  output wire                enc2_index_input,
  output wire                uart1_receive_input,
  output wire                uart2_receive_input
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Source multiplexer for one selector
  function route;
    input [6:0]   code;
    input [6:0]   top;
    input [127:0] pins;
    input         cmp;
    begin
      if (code == `PIRS_CODE_GROUND)
      begin
        route = 1'b0;
      end
      else if (code == `PIRS_CODE_COMPARATOR_ONE_OUTPUT)
      begin
        route = cmp;
      end
      // Codes past the top pin read back as written but route low
      else if (code > top)
      begin
        route = 1'b0;
      end
      else
      begin
        route = pins[code];
      end
    end
  endfunction

  // Offset decode: index of a mapped register
  function [`PIRS_IDX_W-1:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      reg_index = addr[`PIRS_IDX_W+1:2];
    end
  endfunction

  // Unaligned or past the last register counts as unmapped
  function mapped;
    input [ADDR_W-1:0] addr;
    begin
      mapped = (addr[1:0] == 2'b00) &&
               ((addr >> 2) < `PIRS_NUM_REGS);
    end
  endfunction

  // Masking at write time keeps every unused bit reading zero
  // Implemented bits of each register
  function [15:0] field_mask;
    input [`PIRS_IDX_W-1:0] idx;
    begin
      case (idx)
        3'd0:    field_mask = `PIRS_MASK_ONE;
        3'd6:    field_mask = `PIRS_MASK_ONE;
        3'd7:    field_mask = `PIRS_MASK_ONE;
        default: field_mask = `PIRS_MASK_TWO;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------------------
  // Qualified transfers on each channel; protection bits are ignored
  wire                    aw_take;
  wire                    w_take;
  wire                    b_done;
  wire                    ar_take;
  wire                    r_done;
  wire                    rd_hit;
  wire [`PIRS_IDX_W-1:0]  rd_idx;

  // One transfer per channel at an edge with valid and ready both high
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign b_done  = s_axi_bvalid && s_axi_bready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_done  = s_axi_rvalid && s_axi_rready;
  assign rd_hit  = mapped(s_axi_araddr);
  assign rd_idx  = reg_index(s_axi_araddr);

  // --------------------------------------------------------------------------
  // Selector registers
  // --------------------------------------------------------------------------
  reg  [15:0]             sel_reg [0:`PIRS_NUM_REGS-1];
  reg  [ADDR_W-1:0]       awaddr_reg;
  reg                     aw_held_reg;
  reg  [31:0]             wdata_reg;
  reg  [3:0]              wstrb_reg;
  reg                     w_held_reg;
  wire                    do_write;
  wire [`PIRS_IDX_W-1:0]  wr_idx;
  wire [15:0]             wr_mask;
  wire [15:0]             lane_mask;
  wire [15:0]             wr_next;
  wire                    wr_hit;
  integer                 i;

  assign do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx    = reg_index(awaddr_reg);
  assign wr_mask   = field_mask(wr_idx);
  // Strobes 0 and 1 cover the implemented half of the word
  assign lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_next   = (sel_reg[wr_idx] & ~lane_mask) |
                     (wdata_reg[15:0] & lane_mask & wr_mask);
  // Unmapped or unaligned writes are answered with an error and change nothing
  assign wr_hit    = do_write && mapped(awaddr_reg);

  // Reset clears every selector, which grounds every peripheral input
  always @(posedge clk)
  begin
    if (srst)
    begin
      for (i = 0; i < `PIRS_NUM_REGS; i = i + 1)
      begin
        sel_reg[i] <= `PIRS_SEL_RESET;
      end
    end
    else if (wr_hit)
    begin
      sel_reg[wr_idx] <= wr_next;
    end
  end

  // --------------------------------------------------------------------------
  // Write ready
  // --------------------------------------------------------------------------
  // Both readies stay low while a pair is held or its response waits, so a
  // second write cannot slip in before the first is answered
  always @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else if (do_write || s_axi_bvalid)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !aw_take;
      s_axi_wready  <= !w_held_reg && !w_take;
    end
  end

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= {ADDR_W{1'b0}};
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PIRS_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? `PIRS_RESP_OKAY : `PIRS_RESP_DECERR;
      end
      else if (b_done)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read ready
  // --------------------------------------------------------------------------
  // A new address is taken only once the previous data has been accepted
  always @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
    end
    else if (!s_axi_rvalid || s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  // Unmapped reads return zero with an error response
  always @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PIRS_RESP_OKAY;
    end
    else
    begin
      if (ar_take)
      begin
        s_axi_rvalid  <= 1'b1;
        if (rd_hit)
        begin
          s_axi_rdata <= {16'h0000, sel_reg[rd_idx]};
          s_axi_rresp <= `PIRS_RESP_OKAY;
        end
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `PIRS_RESP_DECERR;
        end
      end
      else if (r_done)
      begin
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Selector fields
  // --------------------------------------------------------------------------
  wire [6:0] oc_fault_a_source_sel;
  wire [6:0] pwm_fault1_source_sel;
  wire [6:0] pwm_fault2_source_sel;
  wire [6:0] enc1_phase_a_source_sel;
  wire [6:0] enc1_phase_b_source_sel;
  wire [6:0] enc1_home_source_sel;
  wire [6:0] enc1_index_source_sel;
  wire [6:0] enc2_phase_a_source_sel;
  wire [6:0] enc2_phase_b_source_sel;
  wire [6:0] enc2_home_source_sel;
  wire [6:0] enc2_index_source_sel;
  wire [6:0] uart1_receive_source_sel;
  wire [6:0] uart2_receive_source_sel;

  assign oc_fault_a_source_sel    = sel_reg[0][6:0];
  assign pwm_fault1_source_sel    = sel_reg[1][6:0];
  assign pwm_fault2_source_sel    = sel_reg[1][14:8];
  assign enc1_phase_a_source_sel  = sel_reg[2][6:0];
  assign enc1_phase_b_source_sel  = sel_reg[2][14:8];
  assign enc1_index_source_sel    = sel_reg[3][6:0];
  assign enc1_home_source_sel     = sel_reg[3][14:8];
  assign enc2_phase_a_source_sel  = sel_reg[4][6:0];
  assign enc2_phase_b_source_sel  = sel_reg[4][14:8];
  assign enc2_index_source_sel    = sel_reg[5][6:0];
  assign enc2_home_source_sel     = sel_reg[5][14:8];
  assign uart1_receive_source_sel = sel_reg[6][6:0];
  assign uart2_receive_source_sel = sel_reg[7][6:0];

  // --------------------------------------------------------------------------
  // Routing to peripheral inputs
  // --------------------------------------------------------------------------
  // Combinational from the held selector, so a write shows the cycle after it
  assign oc_fault_a_input    = route(oc_fault_a_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign pwm_fault1_input    = route(pwm_fault1_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign pwm_fault2_input    = route(pwm_fault2_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign enc1_phase_a_input  = route(enc1_phase_a_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign enc1_phase_b_input  = route(enc1_phase_b_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign enc1_home_input     = route(enc1_home_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign enc1_index_input    = route(enc1_index_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign enc2_phase_a_input  = route(enc2_phase_a_source_sel, `PIRS_CODE_TOP_WIDE,
                                     remappable_pin, comparator_one_output);
  assign enc2_phase_b_input  = route(enc2_phase_b_source_sel, `PIRS_CODE_TOP_WIDE,
                                     remappable_pin, comparator_one_output);
  assign enc2_home_input     = route(enc2_home_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign enc2_index_input    = route(enc2_index_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign uart1_receive_input = route(uart1_receive_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);
  assign uart2_receive_input = route(uart2_receive_source_sel, `PIRS_CODE_TOP_STD,
                                     remappable_pin, comparator_one_output);

endmodule // pirs_remap

`default_nettype wire

//--- verif/pirs_remap_asserts.sv
// Port checker for the input remap selects
`include "pirs_map.vh"
`default_nettype none
module pirs_remap_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              oc_fault_a_input,
  input wire logic              enc2_phase_b_input,
  input wire logic              uart1_receive_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_unused_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7])
    else $error("unused read bits not zero");
  a_reset_ground: assert property (
    $past(srst) |-> !oc_fault_a_input && !enc2_phase_b_input && !uart1_receive_input)
    else $error("input not grounded after reset");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 'h20 |-> ##[1:2]
      s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == `PIRS_RESP_DECERR)
    else $error("unmapped read answered wrongly");
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == `PIRS_RESP_DECERR);
endmodule // pirs_remap_asserts

bind pirs_remap pirs_remap_asserts #(.ADDR_W(ADDR_W)) u_pirs_remap_asserts (
  .clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .oc_fault_a_input, .enc2_phase_b_input, .uart1_receive_input
);
`default_nettype wire

//--- verif/pirs_pin_model.sv
// Pin and comparator source model for the remap selects
`default_nettype none
module pirs_pin_model (
  input  wire logic         clk,
  output var  logic [127:0] pins = '0,
  output var  logic         cmp = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 92;
  // --------------------------------------------------------------------------
  // Fresh random levels every cycle so a stale route matches only by chance
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    pins <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    cmp  <= 1'($random(seed));
  end
endmodule // pirs_pin_model
`default_nettype wire

//--- verif/tb_pirs_remap.sv
// Self-checking bench for the input remap selects
`include "pirs_map.vh"
`default_nettype none
module tb_pirs_remap;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire [127:0] remappable_pin;
  wire         comparator_one_output;
  wire [12:0]  outs;
  logic [15:0] shadow [8];
  logic [6:0]  codes [6] = '{7'h00, 7'h01, 7'h02, 7'h7c, 7'h7d, 7'h7f};
  int          ri [13] = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 7};
  logic [12:0] hi = 13'h0334;
  int          errors = 0, tests_run = 0, seed = 92, r;

  pirs_remap u_pirs_remap (
    .clk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .remappable_pin, .comparator_one_output, .oc_fault_a_input(outs[0]),
    .pwm_fault1_input(outs[1]), .pwm_fault2_input(outs[2]), .enc1_phase_a_input(outs[3]),
    .enc1_phase_b_input(outs[4]), .enc1_home_input(outs[5]), .enc1_index_input(outs[6]),
    .enc2_phase_a_input(outs[7]), .enc2_phase_b_input(outs[8]), .enc2_home_input(outs[9]),
    .enc2_index_input(outs[10]), .uart1_receive_input(outs[11]),
    .uart2_receive_input(outs[12])
  );
  pirs_pin_model u_pirs_pin_model (.clk, .pins(remappable_pin), .cmp(comparator_one_output));

  always #2 clk = ~clk;

  // --------------------------------------------------------------------------
  // Compare, bus and expectation helpers
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    logic [15:0] m;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(rs));
    m = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    m = m & ((a[4:2] == 0 || a[4:2] > 5) ? `PIRS_MASK_ONE : `PIRS_MASK_TWO);
    if (rs == `PIRS_RESP_OKAY) shadow[a[4:2]] = (shadow[a[4:2]] & ~m) | (d[15:0] & m);
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, d);
    check(32'(s_axi_rresp), 32'(rs));
    @(posedge clk);
  endtask

  task automatic rd_all();
    for (int j = 0; j < 8; j++) rd(8'(j * 4), {16'h0, shadow[j]}, `PIRS_RESP_OKAY);
  endtask

  function automatic logic route(int i);
    logic [6:0] c;
    c = hi[i] ? shadow[ri[i]][14:8] : shadow[ri[i]][6:0];
    if (c == `PIRS_CODE_GROUND) return 1'b0;
    if (c == `PIRS_CODE_COMPARATOR_ONE_OUTPUT) return comparator_one_output;
    if (c > ((i == 7 || i == 8) ? `PIRS_CODE_TOP_WIDE : `PIRS_CODE_TOP_STD)) return 1'b0;
    return remappable_pin[c];
  endfunction

  task automatic check_outs();
    logic [12:0] e;
    @(negedge clk);
    for (int i = 0; i < 13; i++) e[i] = route(i);
    check(32'(outs), 32'(e));
    @(posedge clk);
  endtask

  task automatic results();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    foreach (shadow[j]) shadow[j] = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check_outs();
    rd_all();
    $display("test reset done");
    foreach (codes[k])
    begin
      for (int j = 0; j < 8; j++) wr(8'(j * 4), {16'hffff, 1'b1, codes[k], 1'b1, codes[k]}, 2'b00);
      rd_all();
      repeat (3) check_outs();
    end
    $display("test corner codes done");
    repeat (40)
    begin
      r = {$random(seed)} % 8;
      s_axi_wstrb <= 4'($random(seed));
      wr(8'(r * 4), $random(seed), `PIRS_RESP_OKAY);
      rd(8'(r * 4), {16'h0, shadow[r]}, `PIRS_RESP_OKAY);
      check_outs();
    end
    $display("test random selects done");
    wr(8'h20, 32'h7f7f, `PIRS_RESP_DECERR);
    wr(8'h02, 32'h7f7f, `PIRS_RESP_DECERR);
    rd(8'h20, 32'h0, `PIRS_RESP_DECERR);
    rd_all();
    $display("test unmapped access done");
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    foreach (shadow[j]) shadow[j] = '0;
    @(posedge clk);
    check_outs();
    rd_all();
    $display("test second reset done");
    results();
  end

  initial
  begin
    #40000;
    errors++;
    results();
  end
endmodule // tb_pirs_remap
`default_nettype wire
